// >>> hw/bsr_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides
module bsr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_MAX = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	wire push = wr_valid_in && wr_ready_out;
	wire pop = rd_valid_out && rd_ready_in;

	assign wr_ready_out = (count_ff != CNT_MAX);
	assign rd_valid_out = (count_ff != '0);
	assign rd_data_out = mem[rd_ptr_ff];

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr_ff] <= wr_data_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			end
			if (pop) begin
				rd_ptr_ff <= ptr_inc(rd_ptr_ff);
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : bsr_fifo

// >>> hw/bsr_pkg.sv
// Constants shared by the bidirectional shift register and its event FIFO
package bsr_pkg;
	localparam int BSR_STAGES = 32;
	localparam int BSR_FIFO_DEPTH = 32;
	localparam int BSR_WORD_W = 5;
	// Event word field positions
	localparam int BSR_F_FALL = 4;
	localparam int BSR_F_DIR = 3;
	localparam int BSR_F_RECIRC = 2;
	localparam int BSR_F_SR = 1;
	localparam int BSR_F_SL = 0;
	// Pin positions in the synchroniser word
	localparam int BSR_P_CLK = 5;
	localparam int BSR_P_INH = 4;
	localparam int BSR_P_DIR = 3;
	localparam int BSR_P_REC = 2;
	localparam int BSR_P_SR = 1;
	localparam int BSR_P_SL = 0;
	// Core cycles after reset before pin edges are trusted
	localparam int BSR_WARM_CYCLES = 3;
	localparam int BSR_FIRST = 0;
	localparam int BSR_LAST = BSR_STAGES - 1;
	localparam logic BSR_OUT_RST = 1'h0;
	localparam logic BSR_SYNC_RST = 1'h0;
	// Core clock, 20 MHz
	localparam int BSR_CLK_PERIOD_NS = 50;
endpackage : bsr_pkg

// >>> hw/bsr_shift32.sv
// 32-stage left/right static shift register sampled from pins
//
// Behaviour
// - Thirty-two storage stages hold their data for as long as the shift clock stands still.
// - A rising edge loads the shift-right input into stage 1 when direction low, recirculate high, inhibit low.
// - A rising edge loads the shift-left input into stage 32 when direction and recirculate high, inhibit low.
// - Each uninhibited rising edge that finds room in the event queue moves every stage one place, toward 32 for direction low, toward 1 for high.
// - With inhibit high a rising edge changes no stage and no output.
// - With recirculate low stage 32 feeds stage 1 going right, and stage 1 feeds stage 32 going left.
// - Serial outputs take their end stages only on the falling edge after a shift.
// - The shift-left output shows stage 1 and the shift-right output shows stage 32.
module bsr_shift32
	import bsr_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic shift_clk_in,
	input wire logic inhibit_in,
	input wire logic dir_left_in,
	input wire logic recirc_in,
	input wire logic sr_data_in,
	input wire logic sl_data_in,
	input wire logic pause_in,
	output logic sl_data_out,
	output logic sr_data_out,
	output logic evt_ready_out
);
	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	// Pins share one sync depth so data stays aligned with its edge
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	logic clk_dly_ff;
	wire [NSYNC-1:0] pins = {shift_clk_in, inhibit_in, dir_left_in, recirc_in,
		sr_data_in, sl_data_in};
	wire s_clk = sync2_ff[BSR_P_CLK];
	wire s_inh = sync2_ff[BSR_P_INH];
	wire s_dir = sync2_ff[BSR_P_DIR];
	wire s_rec = sync2_ff[BSR_P_REC];
	wire s_sr = sync2_ff[BSR_P_SR];
	wire s_sl = sync2_ff[BSR_P_SL];

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_ff <= {NSYNC{BSR_SYNC_RST}};
		end else begin
			sync1_ff <= pins;
		end
	end

	// Only the second stage is read, never the first
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync2_ff <= {NSYNC{BSR_SYNC_RST}};
		end else begin
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clk_dly_ff <= BSR_SYNC_RST;
		end else begin
			clk_dly_ff <= s_clk;
		end
	end

	// --------------------------------------------------------------
	// Start-up guard
	// --------------------------------------------------------------
	// Sync flops reset low, so a pin held high across reset would look like
	// a rising edge; the first level seen is taken as the idle level instead
	localparam logic [1:0] WARM_DONE = 2'(BSR_WARM_CYCLES);
	logic [1:0] warm_ff;
	wire warm = (warm_ff == WARM_DONE);

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			warm_ff <= 2'h0;
		end else if (!warm) begin
			warm_ff <= warm_ff + 2'h1;
		end
	end

	// --------------------------------------------------------------
	// Edge events into the FIFO
	// --------------------------------------------------------------
	function automatic logic edge_seen(
		input logic now_lvl,
		input logic old_lvl,
		input logic upward
	);
		edge_seen = upward ? (now_lvl && !old_lvl) : (!now_lvl && old_lvl);
	endfunction : edge_seen

	wire rise = warm && edge_seen(s_clk, clk_dly_ff, 1'h1);
	wire fall = warm && edge_seen(s_clk, clk_dly_ff, 1'h0);
	// Inhibited rising edges never become events
	wire evt_valid = (rise && !s_inh) || fall;

	// --------------------------------------------------------------
	// Event word
	// --------------------------------------------------------------
	logic [BSR_WORD_W-1:0] evt_word;
	always_comb begin
		evt_word = '0;
		evt_word[BSR_F_FALL] = fall;
		evt_word[BSR_F_DIR] = s_dir;
		evt_word[BSR_F_RECIRC] = s_rec;
		evt_word[BSR_F_SR] = s_sr;
		evt_word[BSR_F_SL] = s_sl;
	end

	// --------------------------------------------------------------
	// Event queue
	// --------------------------------------------------------------
	// Edges arriving while the queue is full are dropped, never stalled
	logic fifo_wr_ready;
	logic [BSR_WORD_W-1:0] q_word;
	logic q_valid;
	wire q_pop = q_valid && !pause_in;

	bsr_fifo #(
		.WIDTH(BSR_WORD_W),
		.DEPTH(BSR_FIFO_DEPTH)
	) u_fifo (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.wr_data_in(evt_word),
		.wr_valid_in(evt_valid),
		.wr_ready_out(fifo_wr_ready),
		.rd_data_out(q_word),
		.rd_valid_out(q_valid),
		.rd_ready_in(!pause_in)
	);

	// --------------------------------------------------------------
	// Shift engine
	// --------------------------------------------------------------
	// No reset on the chain: contents are unknown until filled
	logic [BSR_STAGES-1:0] stage_ff;
	logic shifted_ff;
	logic sl_out_ff;
	logic sr_out_ff;
	logic ready_ff;

	// Serial pin when recirculate is high, the far end stage when low
	function automatic logic fill_bit(
		input logic take_pin,
		input logic pin_bit,
		input logic end_bit
	);
		fill_bit = take_pin ? pin_bit : end_bit;
	endfunction : fill_bit

	// Rises shift the chain, falls update the outputs
	wire q_fall = q_word[BSR_F_FALL];
	wire q_left = q_word[BSR_F_DIR];
	wire q_rec = q_word[BSR_F_RECIRC];
	wire do_shift = q_pop && !q_fall;
	wire do_out = q_pop && q_fall && shifted_ff;

	// --------------------------------------------------------------
	// Input bit selection
	// --------------------------------------------------------------
	wire right_in = fill_bit(q_rec, q_word[BSR_F_SR], stage_ff[BSR_LAST]);
	wire left_in = fill_bit(q_rec, q_word[BSR_F_SL], stage_ff[BSR_FIRST]);
	wire [BSR_STAGES-1:0] nxt_right = {stage_ff[BSR_LAST-1:BSR_FIRST], right_in};
	wire [BSR_STAGES-1:0] nxt_left = {left_in, stage_ff[BSR_LAST:BSR_FIRST+1]};
	wire [BSR_STAGES-1:0] nxt_stage = q_left ? nxt_left : nxt_right;

	// --------------------------------------------------------------
	// Stage chain
	// --------------------------------------------------------------
	// No reset branch, so the chain maps onto plain flops
	always_ff @(posedge core_clk_in) begin
		if (do_shift) begin
			stage_ff <= nxt_stage;
		end
	end

	// --------------------------------------------------------------
	// Fall tracking and serial outputs
	// --------------------------------------------------------------
	// A fall with no shift since the last one leaves both outputs alone
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			shifted_ff <= 1'h0;
		end else if (do_shift) begin
			shifted_ff <= 1'h1;
		end else if (q_pop && q_fall) begin
			shifted_ff <= 1'h0;
		end
	end

	// Both ends move on the same fall so a cascade sees one edge
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sl_out_ff <= BSR_OUT_RST;
			sr_out_ff <= BSR_OUT_RST;
		end else if (do_out) begin
			sl_out_ff <= stage_ff[BSR_FIRST];
			sr_out_ff <= stage_ff[BSR_LAST];
		end
	end

	// --------------------------------------------------------------
	// Queue status
	// --------------------------------------------------------------
	// One cycle late, traded for an output straight from a flop
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ready_ff <= 1'h1;
		end else begin
			ready_ff <= fifo_wr_ready;
		end
	end

	assign sl_data_out = sl_out_ff;
	assign sr_data_out = sr_out_ff;
	assign evt_ready_out = ready_ff;
endmodule : bsr_shift32

// >>> testbench/bsr_pins.sv
// Neighbouring logic that clocks the pins
module bsr_pins (
	input wire logic core_clk_in,
	input wire logic go_in,
	output logic pin_clk_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_ff = 4'h0;
	// Eight core cycles a level, far above the synchroniser need
	always_ff @(posedge core_clk_in) begin
		if (go_in || cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
	assign pin_clk_out = cnt_ff[3];
endmodule : bsr_pins

// >>> testbench/bsr_shift32_asserts.sv
// Port checker for the shift register
module bsr_shift32_asserts (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic shift_clk_in,
	input wire logic pause_in,
	input wire logic sl_data_out,
	input wire logic sr_data_out,
	input wire logic evt_ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Long enough for a full queue to drain
	logic [5:0] calm_ff;
	logic [5:0] quiet_ff;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			calm_ff <= 6'h0;
			quiet_ff <= 6'h0;
		end else begin
			calm_ff <= pause_in ? 6'h0 : calm_ff + {5'h0, ~&calm_ff};
			quiet_ff <= (pause_in || $changed(shift_clk_in)) ? 6'h0 :
				quiet_ff + {5'h0, ~&quiet_ff};
		end
	end
	a_reset_values: assert property ($rose(arst_n_in) |-> evt_ready_out && !sl_data_out)
		else $error("bad reset");
	a_quiet_hold: assert property (quiet_ff > 6'h2f |->
		$stable(sl_data_out) && $stable(sr_data_out))
		else $error("drift");
	a_fall_cause: assert property (calm_ff > 6'h2f && $changed(sl_data_out) |->
		$past(shift_clk_in, 7) && !$past(shift_clk_in, 3))
		else $error("no fall");
	a_out_spaced: assert property (calm_ff > 6'h2f && $changed(sl_data_out) |=>
		$stable(sl_data_out) [*5])
		else $error("spacing");
	a_pause_hold: assert property (pause_in [*5] |->
		$stable(sl_data_out) && $stable(sr_data_out))
		else $error("pause");
	a_full_paused: assert property (!evt_ready_out |-> pause_in || $past(pause_in) || $past(pause_in, 2))
		else $error("full");
	a_ready_back: assert property ($fell(pause_in) |-> ##[1:6] evt_ready_out)
		else $error("stuck");
	a_ready_idle: assert property (calm_ff > 6'h2f |-> evt_ready_out)
		else $error("idle");
endmodule : bsr_shift32_asserts
bind bsr_shift32 bsr_shift32_asserts i_chk (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
	.shift_clk_in(shift_clk_in), .pause_in(pause_in), .sl_data_out(sl_data_out),
	.sr_data_out(sr_data_out), .evt_ready_out(evt_ready_out));

// >>> testbench/test_bsr_shift32.sv
// Bench for the shift register
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected %0t output got %b want %b", $time, (a), (b)); end end
module test_bsr_shift32
	import bsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic inh = 1'h0, dir = 1'h0, rec = 1'h1, sri = 1'h0, sli = 1'h0, pause = 1'h0, go = 1'h0;
	logic pin, slo, sro, rdy;
	logic [31:0] m;
	int num_errors = 0, comparisons = 0, cycles = 0;
	always #(BSR_CLK_PERIOD_NS / 2) clk = ~clk;
	bsr_pins i_pins (.core_clk_in(clk), .go_in(go), .pin_clk_out(pin));
	bsr_shift32 i_dut (.core_clk_in(clk), .arst_n_in(arst_n), .shift_clk_in(pin), .inhibit_in(inh),
		.dir_left_in(dir), .recirc_in(rec), .sr_data_in(sri), .sl_data_in(sli), .pause_in(pause),
		.sl_data_out(slo), .sr_data_out(sro), .evt_ready_out(rdy));
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	// Control word is inhibit, left, recirculate, right data, left data
	task automatic step(input logic [4:0] c, input bit chk);
		@(posedge clk);
		{inh, dir, rec, sri, sli} <= c;
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		repeat (24) @(posedge clk);
		if (!c[4]) begin
			m = c[3] ? {c[2] ? c[0] : m[0], m[31:1]} : {m[30:0], c[2] ? c[1] : m[31]};
		end
		if (chk) begin
			`CHK(slo, m[0])
			`CHK(sro, m[31])
		end
	endtask : step
	task automatic t_right;
		for (int i = 0; i < 40; i++) step({3'h1, i[0] ^ i[2], 1'h0}, i > 31);
	endtask : t_right
	task automatic t_left;
		for (int i = 0; i < 40; i++) step({3'h3, 1'h0, i[1]}, 1'b1);
	endtask : t_left
	task automatic t_recirc;
		for (int i = 0; i < 16; i++) step({1'h0, i[3], 3'h3 ^ i[2]}, 1'b1);
	endtask : t_recirc
	task automatic t_inhibit;
		for (int i = 0; i < 4; i++) step({1'h1, i[1:0], 2'h3}, 1'b1);
	endtask : t_inhibit
	task automatic t_fill;
		{inh, dir, rec, sri, sli} <= 5'h04;
		pause <= 1'h1;
		repeat (17) begin
			@(posedge clk);
			go <= 1'h1;
			@(posedge clk);
			go <= 1'h0;
			repeat (16) @(posedge clk);
		end
		`CHK(rdy, 1'h0)
		pause <= 1'h0;
		repeat (60) @(posedge clk);
		`CHK(rdy, 1'h1)
		repeat (16) m = {m[30:0], 1'h0};
		`CHK(slo, m[0])
		`CHK(sro, m[31])
	endtask : t_fill
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		repeat (4) @(posedge clk);
		t_right();
		t_left();
		t_recirc();
		t_inhibit();
		t_fill();
		report_and_stop();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			num_errors++;
			report_and_stop();
		end
	end
endmodule : test_bsr_shift32
